// *** dv/gdr_control_tb.sv ***
`timescale 1ns/10ps
module gdr_control_tb;
	import gdr_pkg::*;
	localparam logic [4:0] C_REF = 5'h09;
	localparam logic [4:0] C_MRS = 5'h08;
	localparam logic [4:0] C_ACT = 5'h07;
	logic mclk, rst, cke, cs_n, act_n, ras_n, cas_n, we_n;
	logic [2:0] mr_sel;
	logic [15:0] mr_addr, refresh_row;
	logic init_done, sr_enter, sr_exit, gear_2n, cmd_ready, dll_ready;
	logic refresh_busy, banks_idle, in_self_refresh;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	gdr_host_model host (.mclk(mclk), .cke(cke), .cs_n(cs_n), .act_n(act_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mr_sel(mr_sel),
		.mr_addr(mr_addr));
	// Short DLL lock keeps the run brief
	gdr_control #(.TDLLK_CYC(20)) dut (.mclk(mclk), .rst(rst), .cke(cke),
		.cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .mr_sel(mr_sel), .mr_addr(mr_addr),
		.init_done(init_done), .sr_enter(sr_enter), .sr_exit(sr_exit),
		.gear_2n(gear_2n), .cmd_ready(cmd_ready), .dll_ready(dll_ready),
		.refresh_busy(refresh_busy), .banks_idle(banks_idle),
		.refresh_row(refresh_row), .in_self_refresh(in_self_refresh));
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk_bit(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_row(input logic [15:0] e);
		num_checks++;
		if (refresh_row !== e) begin
			miscompares++;
			$display("wrong value refresh_row exp %h got %h", e, refresh_row);
		end
	endtask : chk_row
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic complete_run();
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	task automatic t_gear();
		host.gear(16'h0008);
		chk_bit("gear_2n", 1'h1, gear_2n);
		chk_bit("cmd_ready", 1'h0, cmd_ready);
		cyc(12);
		chk_bit("cmd_ready", 1'h1, cmd_ready);
		chk_bit("dll_ready", 1'h0, dll_ready);
		cyc(12);
		chk_bit("dll_ready", 1'h1, dll_ready);
		host.cmd(C_MRS, 3'h3, 16'h0000, 2);
		cyc(2);
		chk_bit("gear_2n", 1'h1, gear_2n);
	endtask : t_gear
	// Waits out the full refresh cycle so the next one meets precharge
	task automatic t_ref(input logic [15:0] row, input logic rdy);
		host.cmd(C_REF, 3'h5, 16'hA5A5, 1);
		chk_bit("refresh_busy", 1'h1, refresh_busy);
		chk_bit("banks_idle", 1'h0, banks_idle);
		chk_row(row);
		cyc(30);
		chk_bit("cmd_ready", 1'h0, cmd_ready);
		cyc(8);
		chk_bit("banks_idle", 1'h1, banks_idle);
		chk_bit("cmd_ready", rdy, cmd_ready);
	endtask : t_ref
	task automatic t_self();
		sr_enter = 1'h1;
		cyc(1);
		sr_enter = 1'h0;
		chk_bit("in_self_refresh", 1'h1, in_self_refresh);
		chk_bit("gear_2n", 1'h0, gear_2n);
		sr_exit = 1'h1;
		cyc(1);
		sr_exit = 1'h0;
		chk_bit("in_self_refresh", 1'h0, in_self_refresh);
		cyc(36);
		chk_bit("cmd_ready", 1'h0, cmd_ready);
		t_ref(16'h0003, 1'h0);
		host.cmd(C_ACT, 3'h0, 16'h1234, 1);
		cyc(3);
		chk_bit("cmd_ready", 1'h1, cmd_ready);
		chk_bit("gear_2n", 1'h0, gear_2n);
	endtask : t_self
	task automatic t_pdown();
		host.pdown();
		chk_row(16'h0002);
		chk_bit("refresh_busy", 1'h0, refresh_busy);
		chk_bit("cmd_ready", 1'h1, cmd_ready);
	endtask : t_pdown
	// 2N again after self refresh; a gear write while running is refused
	task automatic t_srx_gear();
		host.gear(16'h0008);
		chk_bit("gear_2n", 1'h0, gear_2n);
		sr_enter = 1'h1;
		cyc(1);
		sr_enter = 1'h0;
		sr_exit = 1'h1;
		cyc(1);
		sr_exit = 1'h0;
		cyc(36);
		host.gear(16'h0008);
		chk_bit("gear_2n", 1'h1, gear_2n);
		chk_bit("cmd_ready", 1'h0, cmd_ready);
		cyc(12);
		chk_bit("cmd_ready", 1'h1, cmd_ready);
		chk_bit("dll_ready", 1'h0, dll_ready);
		cyc(12);
		chk_bit("dll_ready", 1'h1, dll_ready);
	endtask : t_srx_gear
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		rst = 1'h1;
		init_done = 1'h0;
		sr_enter = 1'h0;
		sr_exit = 1'h0;
		cyc(16);
		chk_bit("gear_2n", 1'h0, gear_2n);
		chk_bit("dll_ready", 1'h0, dll_ready);
		chk_bit("banks_idle", 1'h1, banks_idle);
		chk_row(16'h0000);
		rst = 1'h0;
		t_gear();
		init_done = 1'h1;
		t_ref(16'h0001, 1'h1);
		t_ref(16'h0002, 1'h1);
		t_pdown();
		t_self();
		t_srx_gear();
		complete_run();
	end
endmodule : gdr_control_tb

// *** dv/gdr_host_model.sv ***
`timescale 1ns/10ps
module gdr_host_model (
	input wire logic mclk,
	output logic cke,
	output logic cs_n,
	output logic act_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] mr_sel,
	output logic [15:0] mr_addr
);
	localparam logic [4:0] REF_CODE = 5'h09;
	// 1X refresh mode: at most 8 postponed or 8 pulled in
	localparam int DEBT_MAX = 8;
	// Power-down residency and exit wait in clocks
	localparam int PD_MIN = 4;
	localparam int XP_PAR = 4;
	// Positive is postponed, negative is pulled in
	int ref_debt = 0;
	initial begin
		cke = 1'h1;
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
		mr_sel = 3'h0;
		mr_addr = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	// Pin order cs_n act_n ras_n cas_n we_n; CS is low one cycle only
	task automatic cmd(input logic [4:0] p, input logic [2:0] s,
		input logic [15:0] a, input int n);
		@(posedge mclk);
		#1;
		{cs_n, act_n, ras_n, cas_n, we_n} = p;
		mr_sel = s;
		mr_addr = a;
		if (p == REF_CODE && ref_debt > -DEBT_MAX) begin
			ref_debt--;
		end
		@(posedge mclk);
		#1;
		cs_n = 1'h1;
		repeat (n - 1) begin
			@(posedge mclk);
			#1;
		end
		// Released lines flip so a stale value never looks valid
		{act_n, ras_n, cas_n, we_n} = ~{act_n, ras_n, cas_n, we_n};
		mr_addr = ~mr_addr;
	endtask : cmd
	// Sync pulse two edges after the MRS edge keeps it on an even boundary
	task automatic gear(input logic [15:0] a);
		@(posedge mclk);
		#1;
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h08;
		mr_sel = 3'h3;
		mr_addr = a;
		@(posedge mclk);
		#1;
		cs_n = 1'h1;
		@(posedge mclk);
		#1;
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h0F;
		@(posedge mclk);
		#1;
		cs_n = 1'h1;
		mr_addr = ~mr_addr;
	endtask : gear
	// Pins are don't care in power-down, so a refresh pattern is sent
	task automatic pdown();
		@(posedge mclk);
		#1;
		cke = 1'h0;
		cs_n = 1'h1;
		@(posedge mclk);
		#1;
		{cs_n, act_n, ras_n, cas_n, we_n} = REF_CODE;
		repeat (PD_MIN - 1) begin
			@(posedge mclk);
			#1;
		end
		cke = 1'h1;
		{cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
		repeat (XP_PAR) begin
			@(posedge mclk);
			#1;
		end
	endtask : pdown
endmodule : gdr_host_model

// *** inc/gdr_pkg.sv ***
package gdr_pkg;
	// Command encoding on cs_n, act_n, ras_n, cas_n, we_n
	localparam logic [4:0] GDR_CMD_REF = 5'h09;
	localparam logic [4:0] GDR_CMD_MRS = 5'h08;
	localparam logic [4:0] GDR_CMD_MASK = 5'h1F;
	localparam int GDR_MR_W = 3;
	localparam logic [2:0] GDR_MR3 = 3'h3;
	localparam int GDR_GEAR_BIT = 3;
	localparam int GDR_ROW_W = 16;
	localparam logic [15:0] GDR_ROW_RST = 16'h0000;
	localparam logic [15:0] GDR_ROW_ONE = 16'h0001;
	localparam int GDR_CNT_W = 16;
	localparam logic [15:0] GDR_CNT_ZERO = 16'h0000;
	localparam logic [15:0] GDR_CNT_ONE = 16'h0001;
	localparam int GDR_CLK_PS = 10000;
	localparam int GDR_TCMD_GEAR_NS = 60;
	localparam int GDR_TDLLK_NS = 4000;
	localparam int GDR_TRFC_NS = 350;
	localparam int GDR_TXS_NS = 360;
	localparam int GDR_TCMD_GEAR_CYC = (GDR_TCMD_GEAR_NS * 1000 +
		GDR_CLK_PS - 1) / GDR_CLK_PS;
	localparam int GDR_TDLLK_CYC = (GDR_TDLLK_NS * 1000 + GDR_CLK_PS - 1) /
		GDR_CLK_PS;
	localparam int GDR_TRFC_CYC = (GDR_TRFC_NS * 1000 + GDR_CLK_PS - 1) /
		GDR_CLK_PS;
	localparam int GDR_TXS_CYC = (GDR_TXS_NS * 1000 + GDR_CLK_PS - 1) /
		GDR_CLK_PS;
	typedef enum logic [2:0] {
		GDR_ST_INIT = 3'h0,
		GDR_ST_RUN = 3'h1,
		GDR_ST_SELF = 3'h3,
		GDR_ST_SRX = 3'h2,
		GDR_ST_SYNC = 3'h6,
		GDR_ST_GEAR = 3'h7
	} gdr_state_t;
endpackage : gdr_pkg

// *** verilog/gdr_control.sv ***
`timescale 1ns/10ps
//
// Contract
// - Gear-down only via MR3 bit 3 entry.
// - Init continues in 2N after tCMD_GEAR.
// - Self refresh forces back to 1N.
// - Non-DLL then DLL commands after sync.
// - 1N exit needs tXS, then a command other than refresh.
// - Internal row counter, banks idle after.
module gdr_control
	import gdr_pkg::*;
#(
	parameter int ROW_W = GDR_ROW_W,
	parameter int TDLLK_CYC = GDR_TDLLK_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] mr_sel,
	input wire logic [15:0] mr_addr,
	input wire logic init_done,
	input wire logic sr_enter,
	input wire logic sr_exit,
	output logic gear_2n,
	output logic cmd_ready,
	output logic dll_ready,
	output logic refresh_busy,
	output logic banks_idle,
	output logic [ROW_W-1:0] refresh_row,
	output logic in_self_refresh
);
	////////////////////////////////////////////////////////////////////////
	gdr_state_t state_ff;
	gdr_state_t nxt_state;
	logic gear_ff;
	logic [ROW_W-1:0] row_ff;
	logic dll_ff;
	logic is_ref;
	logic is_gear_mrs;
	logic sync_pulse;
	logic rfc_done;
	logic gear_done;
	logic xs_done;
	logic dllk_done;
	logic load_rfc;
	logic load_gear;
	logic load_xs;
	logic load_dllk;

	function automatic logic cmd_is(input logic [4:0] bus,
		input logic [4:0] code);
		cmd_is = (bus & GDR_CMD_MASK) == code;
	endfunction : cmd_is

	assign is_ref = cke && cmd_is({cs_n, act_n, ras_n, cas_n, we_n},
		GDR_CMD_REF);
	assign is_gear_mrs = cke && cmd_is({cs_n, act_n, ras_n, cas_n, we_n},
		GDR_CMD_MRS) && (mr_sel == GDR_MR3) && mr_addr[GDR_GEAR_BIT];
	// Sync pulse is a chip select seen while waiting in the sync state
	assign sync_pulse = (state_ff == GDR_ST_SYNC) && !cs_n;

	////////////////////////////////////////////////////////////////////////
	assign load_rfc = is_ref;
	assign load_gear = sync_pulse;
	assign load_dllk = sync_pulse;
	assign load_xs = (state_ff == GDR_ST_SELF) && sr_exit;

	gdr_timer #(.W(GDR_CNT_W)) u_rfc (
		.mclk(mclk), .rst(rst), .load(load_rfc),
		.value(GDR_CNT_W'(GDR_TRFC_CYC)), .done(rfc_done));
	gdr_timer #(.W(GDR_CNT_W)) u_gear (
		.mclk(mclk), .rst(rst), .load(load_gear),
		.value(GDR_CNT_W'(GDR_TCMD_GEAR_CYC)), .done(gear_done));
	gdr_timer #(.W(GDR_CNT_W)) u_xs (
		.mclk(mclk), .rst(rst), .load(load_xs),
		.value(GDR_CNT_W'(GDR_TXS_CYC)), .done(xs_done));
	gdr_timer #(.W(GDR_CNT_W)) u_dllk (
		.mclk(mclk), .rst(rst), .load(load_dllk),
		.value(GDR_CNT_W'(TDLLK_CYC)), .done(dllk_done));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			GDR_ST_INIT: begin
				if (is_gear_mrs) begin
					nxt_state = GDR_ST_SYNC;
				end else if (init_done) begin
					nxt_state = GDR_ST_RUN;
				end
			end
			GDR_ST_RUN: begin
				if (sr_enter) begin
					nxt_state = GDR_ST_SELF;
				end
			end
			GDR_ST_SELF: begin
				if (sr_exit) begin
					nxt_state = GDR_ST_SRX;
				end
			end
			GDR_ST_SRX: begin
				// Gear entry only once tXS has passed
				if (xs_done && is_gear_mrs) begin
					nxt_state = GDR_ST_SYNC;
				end else if (xs_done && !cs_n && !is_ref) begin
					nxt_state = GDR_ST_RUN;
				end
			end
			GDR_ST_SYNC: begin
				if (sync_pulse) begin
					nxt_state = GDR_ST_GEAR;
				end
			end
			GDR_ST_GEAR: begin
				if (gear_done && !load_gear) begin
					nxt_state = GDR_ST_RUN;
				end
			end
			default: begin
				nxt_state = GDR_ST_INIT;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= GDR_ST_INIT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Only reset or self refresh entry clears 2N; MR3 writes can never drop it directly
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gear_ff <= 1'b0;
		end else if (nxt_state == GDR_ST_SELF) begin
			gear_ff <= 1'b0;
		end else if (state_ff == GDR_ST_SYNC && sync_pulse) begin
			gear_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dll_ff <= 1'b0;
		end else if (load_dllk || state_ff == GDR_ST_SELF) begin
			dll_ff <= 1'b0;
		end else if (dllk_done && state_ff == GDR_ST_RUN) begin
			dll_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			row_ff <= GDR_ROW_RST[ROW_W-1:0];
		end else if (is_ref) begin
			row_ff <= row_ff + GDR_ROW_ONE[ROW_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign gear_2n = gear_ff;
	assign cmd_ready = (state_ff == GDR_ST_RUN) && rfc_done;
	assign dll_ready = dll_ff && cmd_ready;
	assign refresh_busy = !rfc_done;
	assign banks_idle = rfc_done;
	assign refresh_row = row_ff;
	assign in_self_refresh = (state_ff == GDR_ST_SELF);

	////////////////////////////////////////////////////////////////////////
	property p_ref_busy;
		@(posedge mclk) disable iff (rst)
		is_ref |=> refresh_busy [*8];
	endproperty
	a_ref_busy: assert property (p_ref_busy)
		else $error("refresh busy not held");

	property p_row_inc;
		@(posedge mclk) disable iff (rst)
		is_ref |=> refresh_row == $past(refresh_row) + GDR_ROW_ONE[ROW_W-1:0];
	endproperty
	a_row_inc: assert property (p_row_inc)
		else $error("row counter did not advance");

	property p_sr_1n;
		@(posedge mclk) disable iff (rst)
		in_self_refresh |-> !gear_2n;
	endproperty
	a_sr_1n: assert property (p_sr_1n)
		else $error("2N held in self refresh");

	property p_gear_wait;
		@(posedge mclk) disable iff (rst)
		(sync_pulse && !is_ref) |=> !cmd_ready [*6];
	endproperty
	a_gear_wait: assert property (p_gear_wait)
		else $error("commands accepted before gear delay");

	property p_gear_set;
		@(posedge mclk) disable iff (rst)
		sync_pulse |=> gear_2n;
	endproperty
	a_gear_set: assert property (p_gear_set)
		else $error("2N not set after sync");

	property p_dll_late;
		@(posedge mclk) disable iff (rst)
		sync_pulse |=> !dll_ready [*8];
	endproperty
	a_dll_late: assert property (p_dll_late)
		else $error("DLL ready too early");

	property p_srx_ready;
		@(posedge mclk) disable iff (rst)
		load_xs |=> !cmd_ready [*8];
	endproperty
	a_srx_ready: assert property (p_srx_ready)
		else $error("ready before exit delay");

	property p_idle;
		@(posedge mclk) disable iff (rst)
		$fell(refresh_busy) |-> banks_idle && $past(refresh_busy, 8);
	endproperty
	a_idle: assert property (p_idle)
		else $error("banks not idle after refresh");

	c_ref: cover property (@(posedge mclk) disable iff (rst) is_ref);
	c_gear: cover property (@(posedge mclk) disable iff (rst)
		state_ff == GDR_ST_GEAR);
	c_sr: cover property (@(posedge mclk) disable iff (rst)
		$fell(in_self_refresh));
endmodule : gdr_control

// *** verilog/gdr_timer.sv ***
`timescale 1ns/10ps
module gdr_timer
	import gdr_pkg::*;
#(
	parameter int W = GDR_CNT_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);
	logic [W-1:0] cnt_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_ff <= GDR_CNT_ZERO[W-1:0];
		end else if (load) begin
			cnt_ff <= value;
		end else if (cnt_ff != GDR_CNT_ZERO[W-1:0]) begin
			cnt_ff <= cnt_ff - GDR_CNT_ONE[W-1:0];
		end
	end

	assign done = (cnt_ff == GDR_CNT_ZERO[W-1:0]) && !load;
endmodule : gdr_timer
